//--- hw/pcs_host.sv
// host sequencer driving the memory's async bus, with an avalon-mm port
`timescale 1ns/10ps
module pcs_host #(
    parameter logic [pcs_pkg::ADDR_W-1:0] OTP_BASE = 23'h000080,
    parameter logic [pcs_pkg::ADDR_W-1:0] OTP_LAST = 23'h000109
) (
    input  wire logic                        sys_clk,
    input  wire logic                        rst_n,
    input  wire logic [2:0]                  avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [31:0]                 avs_writedata,
    output logic [31:0]                      avs_readdata,
    output logic                             avs_waitrequest,
    output pcs_pkg::pcs_pins_type            pin_o,
    input  wire logic [pcs_pkg::DQ_W-1:0]    dq_in
);
    import pcs_pkg::*;

    pcs_state_type     state_r;
    pcs_op_type        op_r;
    logic [1:0]        conf_r;
    logic              autoclr_r;
    logic [ADDR_W-1:0] addr_r;
    logic [DQ_W-1:0]   wdata_r;
    logic [2:0]        step_r;
    logic [7:0]        cnt_r;
    logic              adv_r;
    logic              clr_pend_r;
    logic              busy_r;
    logic              refused_r;
    logic              susp_r;
    logic [ADDR_W-BLK_SHIFT-1:0] susp_blk_r;
    logic [7:0]        stat_r;
    logic [DQ_W-1:0]   rdata_r;
    logic              lock_ok_r;
    logic [DQ_W-1:0]   dq_s1_r;
    logic [DQ_W-1:0]   dq_s2_r;
    logic [7:0]        last_wr_r;
    logic [7:0]        prev_wr_r;
    logic              wait_r;
    logic [31:0]       rdat_r;
    pcs_pins_type      pins_r;
    pcs_step_type      cur;
    logic              start;
    logic              refuse;
    logic [7:0]        conf_code;
    pcs_op_type        new_op;
    logic [ADDR_W-1:0] cyc_addr;

    assign pin_o           = pins_r;
    assign avs_waitrequest = wait_r;
    assign avs_readdata    = rdat_r;

    // confirm code of a locking change
    always_comb begin
        case (conf_r)
            2'h1:    conf_code = CMD_CONFIRM;
            2'h2:    conf_code = CMD_LOCKDOWN;
            default: conf_code = CMD_LOCK;
        endcase
    end

    // step table: the bus cycles each operation issues, in order
    always_comb begin
        cur = '{kind: K_END, data: 8'h00, plus2: 1'b0};
        case (op_r)
            OP_READ_ARRAY: begin
                case (step_r)
                    3'h0: cur = '{K_WR, CMD_READ_ARRAY, 1'b0};
                    3'h1: cur = '{K_RD, 8'h00, 1'b0};
                    default: ;
                endcase
            end
            OP_PROGRAM: begin
                case (step_r)
                    3'h0: cur = '{K_WR, CMD_PROGRAM, 1'b0};
                    3'h1: cur = '{K_WRD, 8'h00, 1'b0};
                    3'h2: cur = '{K_POLL, 8'h00, 1'b0};
                    3'h3: cur = '{K_WR, CMD_READ_ARRAY, 1'b0};
                    default: ;
                endcase
            end
            OP_ERASE: begin
                case (step_r)
                    3'h0: cur = '{K_WR, CMD_ERASE, 1'b0};
                    3'h1: cur = '{K_WR, CMD_CONFIRM, 1'b0};
                    default: ;
                endcase
            end
            OP_SUSPEND: begin
                case (step_r)
                    3'h0: cur = '{K_WR, CMD_READ_STAT, 1'b0};
                    3'h1: cur = '{K_WR, CMD_SUSPEND, 1'b0};
                    3'h2: cur = '{K_POLL, 8'h00, 1'b0};
                    default: ;
                endcase
            end
            OP_RESUME: begin
                if (step_r == 3'h0) begin
                    cur = '{K_WR, CMD_CONFIRM, 1'b0};
                end
            end
            OP_LOCK: begin
                case (step_r)
                    3'h0: cur = '{K_WR, CMD_LOCK_SETUP, 1'b0};
                    3'h1: cur = '{K_WR, conf_code, 1'b0};
                    3'h2: cur = '{K_WR, CMD_READ_ID, 1'b1};
                    3'h3: cur = '{K_RD, 8'h00, 1'b1};
                    3'h4: cur = '{K_WR, CMD_READ_ARRAY, 1'b0};
                    default: ;
                endcase
            end
            OP_OTP: begin
                case (step_r)
                    3'h0: cur = '{K_WR, CMD_OTP_SETUP, 1'b0};
                    3'h1: cur = '{K_WRD, 8'h00, 1'b0};
                    3'h2: cur = '{K_POLL, 8'h00, 1'b0};
                    3'h3: cur = '{K_WR, CMD_READ_ARRAY, 1'b0};
                    default: ;
                endcase
            end
            OP_CLR: begin
                if (step_r == 3'h0) begin
                    cur = '{K_WR, CMD_CLR_STAT, 1'b0};
                end
            end
            OP_STATUS: begin
                case (step_r)
                    3'h0: cur = '{K_WR, CMD_READ_STAT, 1'b0};
                    3'h1: cur = '{K_POLL, 8'h00, 1'b0};
                    default: ;
                endcase
            end
            OP_READ: begin
                if (step_r == 3'h0) begin
                    cur = '{K_RD, 8'h00, 1'b0};
                end
            end
            default: ;
        endcase
    end

    // start decode; while suspended only safe commands go out
    assign new_op = pcs_op_type'(avs_writedata[3:0]);
    assign start  = avs_write && !wait_r && (avs_address == REG_CTRL)
                    && !busy_r;
    always_comb begin
        refuse = 1'b0;
        if (avs_writedata[3:0] > 4'h9) begin
            refuse = 1'b1;
        end else if (susp_r) begin
            case (new_op)
                OP_PROGRAM: refuse = (addr_r[ADDR_W-1:BLK_SHIFT]
                                      == susp_blk_r);
                OP_ERASE, OP_LOCK, OP_OTP, OP_SUSPEND: refuse = 1'b1;
                default: refuse = 1'b0;
            endcase
        end
        if (new_op == OP_OTP && (addr_r < OTP_BASE || addr_r > OTP_LAST)) begin
            refuse = 1'b1;  // keep out-of-range protection writes off the bus
        end
    end

    assign cyc_addr = cur.plus2 ? addr_r + LOCK_STAT_OFS : addr_r;

    // read data arrive from pins: two flops before anything looks at them
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            dq_s1_r <= '0;
            dq_s2_r <= '0;
        end else begin
            dq_s1_r <= dq_in;
            dq_s2_r <= dq_s1_r;
        end
    end

    // bus sequencer and pin drive
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_r    <= S_IDLE;
            pins_r     <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                            addr: '0, dq_out: '0, dq_oe: 1'b0};
            step_r     <= 3'h0;
            cnt_r      <= 8'h00;
            adv_r      <= 1'b0;
            clr_pend_r <= 1'b0;
            busy_r     <= 1'b0;
            last_wr_r  <= 8'h00;
            prev_wr_r  <= 8'h00;
        end else begin
            case (state_r)
                S_IDLE: begin
                    if (start && !refuse) begin
                        busy_r  <= 1'b1;
                        step_r  <= 3'h0;
                        state_r <= S_FETCH;
                    end
                end
                S_FETCH: begin
                    pins_r.addr <= cyc_addr;
                    cnt_r       <= WP_CYC;
                    adv_r       <= !clr_pend_r;
                    if (clr_pend_r) begin
                        // clear error flags ahead of the closing FFh
                        pins_r.dq_out <= {8'h00, CMD_CLR_STAT};
                        last_wr_r     <= CMD_CLR_STAT;
                        prev_wr_r     <= last_wr_r;
                        clr_pend_r    <= 1'b0;
                        pins_r.ce_n   <= 1'b0;
                        pins_r.we_n   <= 1'b0;
                        pins_r.dq_oe  <= 1'b1;
                        state_r       <= S_WR;
                    end else if (cur.kind == K_WR || cur.kind == K_WRD) begin
                        pins_r.dq_out <= (cur.kind == K_WRD) ? wdata_r
                                         : {8'h00, cur.data};
                        last_wr_r     <= (cur.kind == K_WRD) ? wdata_r[7:0]
                                         : cur.data;
                        prev_wr_r     <= last_wr_r;
                        pins_r.ce_n   <= 1'b0;
                        pins_r.we_n   <= 1'b0;
                        pins_r.dq_oe  <= 1'b1;
                        state_r       <= S_WR;
                    end else if (cur.kind == K_RD || cur.kind == K_POLL) begin
                        pins_r.ce_n <= 1'b0;
                        pins_r.oe_n <= 1'b0;
                        cnt_r       <= ACC_CYC;
                        state_r     <= S_RD;
                    end else begin
                        state_r <= S_DONE;
                    end
                end
                S_WR: begin
                    cnt_r <= cnt_r - 8'h01;
                    if (cnt_r == 8'h01) begin
                        pins_r.ce_n <= 1'b1;  // data still held past we rise
                        pins_r.we_n <= 1'b1;
                        cnt_r       <= GAP_CYC;
                        state_r     <= S_GAP;
                    end
                end
                S_RD: begin
                    cnt_r <= cnt_r - 8'h01;
                    if (cnt_r == 8'h01) begin
                        // every status look is its own select cycle
                        pins_r.ce_n <= 1'b1;
                        pins_r.oe_n <= 1'b1;
                        cnt_r       <= GAP_CYC;
                        state_r     <= S_GAP;
                        if (cur.kind == K_POLL) begin
                            adv_r <= dq_s2_r[SB_READY];
                            clr_pend_r <= dq_s2_r[SB_READY] && autoclr_r
                                && (dq_s2_r[SB_LOCKED] || dq_s2_r[SB_VPPERR]
                                    || dq_s2_r[SB_PGMERR]);
                        end
                    end
                end
                S_GAP: begin
                    pins_r.dq_oe <= 1'b0;
                    cnt_r        <= cnt_r - 8'h01;
                    if (cnt_r == 8'h01) begin
                        if (adv_r) begin
                            step_r <= step_r + 3'h1;
                        end
                        state_r <= S_FETCH;
                    end
                end
                S_DONE: begin
                    busy_r  <= 1'b0;
                    state_r <= S_IDLE;
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // results: status byte, read word, lock check, suspend tracking
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            stat_r     <= 8'h80;
            rdata_r    <= '0;
            lock_ok_r  <= 1'b0;
            susp_r     <= 1'b0;
            susp_blk_r <= '0;
            refused_r  <= 1'b0;
        end else begin
            if (start) begin
                refused_r <= refuse;
            end
            if (state_r == S_RD && cnt_r == 8'h01) begin
                if (cur.kind == K_POLL) begin
                    stat_r <= dq_s2_r[7:0];
                end else begin
                    rdata_r <= dq_s2_r;
                end
                if (op_r == OP_LOCK && cur.kind == K_RD) begin
                    case (conf_r)
                        2'h1:    lock_ok_r <= !dq_s2_r[0];
                        2'h2:    lock_ok_r <= dq_s2_r[1];
                        default: lock_ok_r <= dq_s2_r[0];
                    endcase
                end
            end
            if (state_r == S_DONE && op_r == OP_SUSPEND) begin
                susp_r     <= stat_r[SB_ESUSP];
                susp_blk_r <= addr_r[ADDR_W-1:BLK_SHIFT];
            end
            if (state_r == S_DONE && op_r == OP_RESUME) begin
                susp_r <= 1'b0;
            end
        end
    end

    // avalon slave: one wait cycle, then the access completes
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wait_r    <= 1'b1;
            rdat_r    <= 32'h00000000;
            op_r      <= OP_READ_ARRAY;
            conf_r    <= 2'h0;
            autoclr_r <= 1'b0;
            addr_r    <= '0;
            wdata_r   <= '0;
        end else begin
            wait_r <= !((avs_read || avs_write) && wait_r);
            if ((avs_read || avs_write) && wait_r) begin
                if (avs_address == REG_STATUS) begin
                    rdat_r <= {16'h0000, stat_r, stat_r[SB_LOCKED],
                               stat_r[SB_PGMERR], stat_r[SB_VPPERR],
                               1'b0, lock_ok_r, susp_r, refused_r, busy_r};
                end else if (avs_address == REG_RDATA) begin
                    rdat_r <= {16'h0000, rdata_r};
                end else if (avs_address == REG_ADDR) begin
                    rdat_r <= {9'h000, addr_r};
                end else if (avs_address == REG_WDATA) begin
                    rdat_r <= {16'h0000, wdata_r};
                end else begin
                    rdat_r <= 32'h00000000;
                end
            end
            if (avs_write && !wait_r && !busy_r) begin
                if (avs_address == REG_CTRL && !refuse) begin
                    op_r      <= new_op;
                    conf_r    <= avs_writedata[CTRL_CONF_LSB +: 2];
                    autoclr_r <= avs_writedata[CTRL_AUTOCLR];
                end else if (avs_address == REG_ADDR) begin
                    addr_r <= avs_writedata[ADDR_W-1:0];
                end else if (avs_address == REG_WDATA) begin
                    wdata_r <= avs_writedata[DQ_W-1:0];
                end
            end
        end
    end

    a_no_bus_fight: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !pins_r.oe_n |-> !pins_r.dq_oe && pins_r.we_n)
        else $error("host drives dq during a read");
    a_status_toggle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_r == S_RD && cnt_r == 8'h01) |=> pins_r.oe_n && pins_r.ce_n)
        else $error("status read not ended by a select toggle");
    a_suspend_order: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ($fell(pins_r.we_n) && op_r == OP_SUSPEND && last_wr_r == CMD_SUSPEND)
        |-> prev_wr_r == CMD_READ_STAT)
        else $error("suspend not preceded by read-status");
    a_lock_setup: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ($fell(pins_r.we_n) && op_r == OP_LOCK && step_r == 3'h1)
        |-> prev_wr_r == CMD_LOCK_SETUP && last_wr_r == conf_code)
        else $error("lock confirm without setup");
    a_lock_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ($fell(pins_r.oe_n) && op_r == OP_LOCK)
        |-> pins_r.addr == addr_r + LOCK_STAT_OFS && last_wr_r == CMD_READ_ID)
        else $error("lock status read at wrong address");
    a_otp_setup: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ($fell(pins_r.we_n) && op_r == OP_OTP && step_r == 3'h1)
        |-> prev_wr_r == CMD_OTP_SETUP)
        else $error("protection data without setup");
    a_final_array: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_r == S_DONE && (op_r == OP_LOCK || op_r == OP_OTP
                               || op_r == OP_PROGRAM))
        |-> last_wr_r == CMD_READ_ARRAY)
        else $error("sequence did not end with read-array");
    a_refuse_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (start && refuse) |=> state_r == S_IDLE && !busy_r && refused_r
        ##1 pins_r.ce_n)
        else $error("refused command reached the bus");
    a_clear_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clr_pend_r && state_r == S_FETCH) |=> pins_r.dq_out[7:0]
        == CMD_CLR_STAT && !pins_r.we_n)
        else $error("pending clear-status not issued next");
endmodule : pcs_host

//--- hw/pcs_pkg.sv
// package of constants and types for the phase-change memory host sequencer
package pcs_pkg;
    localparam int ADDR_W = 23;
    localparam int DQ_W   = 16;
    localparam int BLK_SHIFT = 16;           // words per main block, as log2

    // device command codes
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_PROGRAM    = 8'h40;
    localparam logic [7:0] CMD_ERASE      = 8'h20;
    localparam logic [7:0] CMD_CONFIRM    = 8'hD0;
    localparam logic [7:0] CMD_READ_STAT  = 8'h70;
    localparam logic [7:0] CMD_SUSPEND    = 8'hB0;
    localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
    localparam logic [7:0] CMD_LOCK       = 8'h01;
    localparam logic [7:0] CMD_LOCKDOWN   = 8'h2F;
    localparam logic [7:0] CMD_READ_ID    = 8'h90;
    localparam logic [7:0] CMD_OTP_SETUP  = 8'hC0;
    localparam logic [7:0] CMD_CLR_STAT   = 8'h50;

    // status bit positions
    localparam int SB_READY  = 7;
    localparam int SB_ESUSP  = 6;
    localparam int SB_PGMERR = 4;
    localparam int SB_VPPERR = 3;
    localparam int SB_LOCKED = 1;
    localparam logic [ADDR_W-1:0] LOCK_STAT_OFS = 23'h000002;

    // bus cycle timing, ns at a 100 ns clock
    localparam int CLK_NS    = 100;
    localparam int T_WP_NS   = 100;
    localparam int T_ACC_NS  = 150;
    localparam int T_GAP_NS  = 100;
    localparam logic [7:0] WP_CYC  = 8'((T_WP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] ACC_CYC = 8'((T_ACC_NS + CLK_NS - 1) / CLK_NS + 2);
    localparam logic [7:0] GAP_CYC = 8'((T_GAP_NS + CLK_NS - 1) / CLK_NS);

    // avalon register indices (word addresses)
    localparam logic [2:0] REG_CTRL   = 3'h0;
    localparam logic [2:0] REG_ADDR   = 3'h1;
    localparam logic [2:0] REG_WDATA  = 3'h2;
    localparam logic [2:0] REG_STATUS = 3'h3;
    localparam logic [2:0] REG_RDATA  = 3'h4;
    localparam int CTRL_CONF_LSB = 4;
    localparam int CTRL_AUTOCLR  = 8;

    typedef enum logic [3:0] {
        OP_READ_ARRAY = 4'h0, OP_PROGRAM = 4'h1, OP_ERASE  = 4'h2,
        OP_SUSPEND    = 4'h3, OP_RESUME  = 4'h4, OP_LOCK   = 4'h5,
        OP_OTP        = 4'h6, OP_CLR     = 4'h7, OP_STATUS = 4'h8,
        OP_READ       = 4'h9
    } pcs_op_type;

    typedef enum logic [2:0] {
        K_WR = 3'h0, K_WRD = 3'h1, K_RD = 3'h2, K_POLL = 3'h3, K_END = 3'h4
    } pcs_kind_type;

    typedef struct packed {
        pcs_kind_type kind;
        logic [7:0]   data;
        logic         plus2;
    } pcs_step_type;

    typedef struct packed {
        logic              ce_n;
        logic              oe_n;
        logic              we_n;
        logic [ADDR_W-1:0] addr;
        logic [DQ_W-1:0]   dq_out;
        logic              dq_oe;
    } pcs_pins_type;

    typedef enum logic [5:0] {
        S_IDLE  = 6'b000001, S_FETCH = 6'b000010, S_WR   = 6'b000100,
        S_RD    = 6'b001000, S_GAP   = 6'b010000, S_DONE = 6'b100000
    } pcs_state_type;
endpackage : pcs_pkg

//--- verification/pcs_dev_model.sv
// behavioural phase-change memory answering the host's async bus
`timescale 1ns/10ps
module pcs_dev_model (
    input  wire pcs_pkg::pcs_pins_type    pin_i,
    input  wire logic [1:0]               fault,
    output logic [pcs_pkg::DQ_W-1:0]      dq_wire
);
    import pcs_pkg::*;
    logic [7:0]  sr = 8'h80, p, c, last = 8'h00;
    logic [1:0]  mode = 2'h0, lk [128] = '{default: 2'h0};
    logic [15:0] mem [int], rv = 16'h0000;
    int          ers = 0;
    wire  [6:0]  blk = pin_i.addr[22:16];
    // a write lands as the strobe rises; a setup code arms the next write
    always @(posedge pin_i.we_n) if (pin_i.dq_oe) begin
        {p, c, last} = {last, pin_i.dq_out[7:0], pin_i.dq_out[7:0]};
        case (p)
            CMD_LOCK_SETUP: begin
                lk[blk] = {lk[blk][1] | c == CMD_LOCKDOWN, c != CMD_CONFIRM};
                last = 8'h00;
            end
            CMD_PROGRAM, CMD_OTP_SETUP: begin
                {mode, last} = {2'h1, 8'h00};
                if (p == CMD_PROGRAM && lk[blk][0]) sr[1] = 1'b1;
                else if (p == CMD_OTP_SETUP && (pin_i.addr < 23'h000080
                         || pin_i.addr > 23'h000109)) sr[4] = 1'b1;
                else if (fault[0]) sr[3] = 1'b1;
                else if (fault[1]) sr[4] = 1'b1;
                else mem[pin_i.addr] = pin_i.dq_out;
            end
            CMD_ERASE: begin
                {mode, last} = {2'h1, 8'h00};
                if (lk[blk][0]) sr[1] = 1'b1;
                else {ers, sr[7]} = {32'd3, 1'b0};
            end
            default: case (c)
                CMD_READ_ARRAY: mode = 2'h0;
                CMD_READ_STAT:  mode = 2'h1;
                CMD_READ_ID:    mode = 2'h2;
                CMD_CLR_STAT:   sr[4:1] = 4'h0;
                CMD_SUSPEND: if (!sr[7]) sr[7:6] = 2'h3;
                CMD_CONFIRM: if (sr[6]) sr[7:6] = 2'h0;
                default: ;
            endcase
        endcase
    end
    // status is refreshed only when select or output gate falls
    always @(negedge pin_i.ce_n or negedge pin_i.oe_n) begin
        // a running erase counts down one step per select or output-gate fall, writes included
        if (mode == 2'h1 && sr[7:6] == 2'h0) begin
            ers = ers - 1;
            if (ers <= 0) sr[7] = 1'b1;
        end
        rv = mode == 2'h1 ? {8'h00, sr} : mode == 2'h2 ? {14'h0, lk[blk]}
           : mem.exists(pin_i.addr) ? mem[pin_i.addr] : ~pin_i.addr[15:0];
    end
    // a released bus shows the inverse word, so stale data cannot pass
    assign dq_wire = pin_i.dq_oe ? pin_i.dq_out
                   : (!pin_i.ce_n && !pin_i.oe_n) ? rv : ~rv;
endmodule : pcs_dev_model

//--- verification/pcm_command_sequencer_tb_top.sv
// self-checking bench: host sequencer against the device model
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
    $display("BAD %0t got %h want %h", $time, g, e); end end
module pcm_command_sequencer_tb_top;
    import pcs_pkg::*;
    logic         sys_clk = 0, rst_n = 0, avs_read = 0, avs_write = 0;
    logic [2:0]   avs_address = 3'h0;
    logic [31:0]  avs_writedata = 32'h0, avs_readdata, rdat, qe, qm;
    logic         avs_waitrequest;
    logic [1:0]   fault = 2'h0, lkx [3] = '{2'h1, 2'h0, 2'h3};
    logic [DQ_W-1:0] dq;
    pcs_pins_type pins;
    logic [63:0]  expq [$];
    logic [22:0]  ba, bb;
    logic [15:0]  wd;
    int           errors = 0, checks_done = 0;
    pcs_host uut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pin_o(pins), .dq_in(dq));
    pcs_dev_model dev (.pin_i(pins), .fault(fault), .dq_wire(dq));
    initial forever #50 sys_clk = ~sys_clk;
    // one avalon transfer; an edge passes first so strobes never double up
    task automatic av(input logic w, input logic [2:0] a, logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rdat = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : av
    task automatic rd(input logic [2:0] a, input logic [31:0] e, m);
        expq.push_back({e, m});
        av(1'b0, a, 32'h0);
    endtask : rd
    // start an operation and poll until the sequencer is idle again
    task automatic op(input logic [22:0] a, input logic [31:0] c);
        av(1'b1, REG_ADDR, {9'h0, a});
        av(1'b1, REG_CTRL, c);
        do rd(REG_STATUS, 32'h0, 32'h0); while (rdat[0] !== 1'b0);
    endtask : op
    // watcher pairs each completed read with the oldest note
    always @(posedge sys_clk) begin
        if (avs_read && avs_waitrequest === 1'b0 && expq.size() > 0) begin
            {qe, qm} = expq.pop_front();
            if (qm != 0) `CHK(avs_readdata & qm, qe)
        end
    end
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    initial begin
        #(20000 * 100);
        errors++;
        end_of_test();
    end
    initial begin
        void'($urandom(32'hD06A0C57));
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        ba = 23'($urandom_range(63, 1)) << 16;
        bb = ba | 23'h400000;
        wd = 16'($urandom);
        rd(3'h5, 32'h0, 32'hFFFFFFFF);
        foreach (lkx[i]) begin
            op(ba, {26'h0, 2'(i), 4'h5});
            rd(REG_STATUS, 32'h8, 32'h8);
            rd(REG_RDATA, {30'h0, lkx[i]}, 32'h3);
        end
        av(1'b1, REG_WDATA, {16'h0, wd});
        op(bb, 32'h1);
        op(bb, 32'h0);
        rd(REG_RDATA, {16'h0, wd}, 32'hFFFF);
        op(bb + 23'h1, 32'h9);
        rd(REG_RDATA, 32'hFFFE, 32'hFFFF);
        op(ba, 32'h1);
        rd(REG_STATUS, 32'h8280, 32'hFFE7);
        fault <= 2'h1;
        op(bb, 32'h1);
        rd(REG_STATUS, 32'h8AA0, 32'hFFE7);
        fault <= 2'h2;
        op(bb, 32'h101);
        rd(REG_STATUS, 32'h9AE0, 32'hFFE7);
        fault <= 2'h0;
        op(ba, 32'h8);
        rd(REG_STATUS, 32'h8000, 32'hFFE7);
        op(ba, 32'h1);
        op(ba, 32'h7);
        op(ba, 32'h8);
        rd(REG_STATUS, 32'h8000, 32'hFFE7);
        op(bb, 32'h2);
        op(bb, 32'h3);
        rd(REG_STATUS, 32'hC004, 32'hFF07);
        op(bb, 32'h1);
        rd(REG_STATUS, 32'h2, 32'h2);
        op(bb, 32'h4);
        op(bb, 32'h8);
        rd(REG_STATUS, 32'h8000, 32'hFF07);
        op(23'h00010A, 32'h6);
        rd(REG_STATUS, 32'h2, 32'h2);
        op(23'h000080, 32'h6);
        rd(REG_STATUS, 32'h8000, 32'hFF02);
        op(ba, 32'hA);
        rd(REG_STATUS, 32'h2, 32'h2);
        end_of_test();
    end
endmodule : pcm_command_sequencer_tb_top
